/* File: shared/xpe_pkg.sv */
package xpe_pkg;

	localparam int PTR_W   = 12;
	localparam int ADDR_W  = 12;
	localparam int PC_W    = 21;
	localparam int DATA_W  = 8;
	localparam int INSTR_W = 16;
	localparam int LIT_W   = 6;
	localparam int OFS_W   = 7;
	localparam int NUM_PTR = 3;

	localparam logic [7:0]  OPC_PTR_ADD    = 8'hE8;
	localparam logic [7:0]  OPC_MOVE_FIRST = 8'hEB;
	localparam logic [15:0] OPC_CALL_WORK  = 16'h0014;
	localparam int          OPC_HI_LSB     = 8;
	localparam int          SEL_LSB        = 6;
	localparam int          MOVE_KIND_BIT  = 7;
	localparam logic [1:0]  SEL_RETURN     = 2'h3;
	localparam logic [1:0]  SEL_FRAME      = 2'h2;

	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q3 = 2'h2;
	localparam logic [1:0] PH_Q4 = 2'h3;

	localparam logic [PC_W-1:0]   PC_RET_STEP    = 21'h000002;
	localparam logic [PTR_W-1:0]  PTR_RST        = 12'h000;
	localparam logic [DATA_W-1:0] MOVE_NULL_DATA = 8'h00;

	// placement of the indirect-access registers; defaults are arbitrary
	localparam logic [ADDR_W-1:0] IND_BASE0 = 12'hF00;
	localparam logic [ADDR_W-1:0] IND_BASE1 = 12'hF08;
	localparam logic [ADDR_W-1:0] IND_BASE2 = 12'hF10;
	localparam logic [ADDR_W-1:0] IND_SPAN  = 12'h005;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_RET_NOP  = 2'b01,
		ST_CALL_NOP = 2'b10,
		ST_MOVE_WR  = 2'b11
	} xpe_state_e;

	function automatic logic xpe_is_indirect(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] d0;
		logic [ADDR_W-1:0] d1;
		logic [ADDR_W-1:0] d2;
		d0 = addr - IND_BASE0;
		d1 = addr - IND_BASE1;
		d2 = addr - IND_BASE2;
		return (d0 < IND_SPAN) | (d1 < IND_SPAN) | (d2 < IND_SPAN);
	endfunction

endpackage

/* File: verilog/xpe_ptr_add.sv */
`timescale 1ns/100ps
module xpe_ptr_add #(
	parameter int PTR_W = 12,
	parameter int LIT_W = 6
) (
	input  wire logic [PTR_W-1:0] base,
	input  wire logic [LIT_W-1:0] lit,
	output wire logic [PTR_W-1:0] sum
);
	import xpe_pkg::*;

	// whole-word add so the low byte carries into the high part
	assign sum = base + {{(PTR_W-LIT_W){1'b0}}, lit};

endmodule

/* File: verilog/xpe_decode.sv */
`timescale 1ns/100ps
module xpe_decode (
	input  wire logic [xpe_pkg::INSTR_W-1:0] instr,
	input  wire logic                        ext_en,
	output wire logic                        is_ptr_add,
	output wire logic                        is_add_ret,
	output wire logic                        is_call_work,
	output wire logic                        is_move,
	output wire logic [1:0]                  ptr_sel,
	output wire logic [xpe_pkg::LIT_W-1:0]   lit,
	output wire logic [xpe_pkg::OFS_W-1:0]   ofs
);
	import xpe_pkg::*;

	wire logic [7:0] opc_hi;
	wire logic       add_form;

	assign opc_hi   = instr[INSTR_W-1:OPC_HI_LSB];
	assign ptr_sel  = instr[SEL_LSB+1:SEL_LSB];
	assign lit      = instr[LIT_W-1:0];
	assign ofs      = instr[OFS_W-1:0];
	// opcodes fall through to the standard set while disabled
	assign add_form = ext_en & (opc_hi == OPC_PTR_ADD);

	assign is_ptr_add   = add_form & (ptr_sel != SEL_RETURN);
	assign is_add_ret   = add_form & (ptr_sel == SEL_RETURN);
	assign is_call_work = ext_en & (instr == OPC_CALL_WORK);
	assign is_move      = ext_en & (opc_hi == OPC_MOVE_FIRST)
		& ~instr[MOVE_KIND_BIT];

endmodule

/* File: verilog/xpe_exec.sv */
`timescale 1ns/100ps
module xpe_exec (
	input  wire logic                        CLK,
	input  wire logic                        RESET_N,
	input  wire logic                        EXT_SET_ENABLE,
	input  wire logic [xpe_pkg::INSTR_W-1:0] INSTR,
	input  wire logic                        INSTR_VALID,
	input  wire logic [xpe_pkg::PC_W-1:0]    PC_NOW,
	input  wire logic [xpe_pkg::DATA_W-1:0]  WORK_REG,
	input  wire logic [xpe_pkg::DATA_W-1:0]  PC_HIGH_LATCH,
	input  wire logic [xpe_pkg::DATA_W-1:0]  PC_UPPER_LATCH,
	input  wire logic [xpe_pkg::PC_W-1:0]    STACK_TOP,
	input  wire logic [xpe_pkg::DATA_W-1:0]  DATA_RD_DATA,
	input  wire logic                        PTR_WR_EN,
	input  wire logic [1:0]                  PTR_WR_SEL,
	input  wire logic [xpe_pkg::PTR_W-1:0]   PTR_WR_DATA,
	output logic      [1:0]                  Q_PHASE,
	output logic                             EXT_CLAIM,
	output logic                             NOP_CYCLE,
	output logic                             PC_LOAD,
	output logic      [xpe_pkg::PC_W-1:0]    PC_LOAD_VALUE,
	output logic                             STACK_PUSH,
	output logic      [xpe_pkg::PC_W-1:0]    STACK_PUSH_VALUE,
	output logic                             STACK_POP,
	output logic                             DATA_RD_EN,
	output logic      [xpe_pkg::ADDR_W-1:0]  DATA_RD_ADDR,
	output logic                             DATA_WR_EN,
	output logic      [xpe_pkg::ADDR_W-1:0]  DATA_WR_ADDR,
	output logic      [xpe_pkg::DATA_W-1:0]  DATA_WR_DATA,
	output logic      [xpe_pkg::PTR_W-1:0]   PTR0,
	output logic      [xpe_pkg::PTR_W-1:0]   PTR1,
	output logic      [xpe_pkg::PTR_W-1:0]   PTR2
);
	import xpe_pkg::*;

	logic              rst_meta_reg;
	logic              rst_sync_n_reg;
	logic              ext_meta_reg;
	logic              ext_en_reg;
	logic [1:0]        q_reg;
	xpe_state_e        state_reg;
	xpe_state_e        state_next;
	logic              claim_reg;
	logic              op_add_reg;
	logic              op_ret_reg;
	logic              op_call_reg;
	logic              op_move_reg;
	logic [1:0]        sel_reg;
	logic [LIT_W-1:0]  lit_reg;
	logic [OFS_W-1:0]  ofs_reg;
	logic              src_ind_reg;
	logic [DATA_W-1:0] move_data_reg;
	logic [ADDR_W-1:0] dest_reg;
	logic [PTR_W-1:0]  ptr_reg [NUM_PTR];

	wire logic              rst_n;
	wire logic              dec_add;
	wire logic              dec_ret;
	wire logic              dec_call;
	wire logic              dec_move;
	wire logic              dec_any;
	wire logic [1:0]        dec_sel;
	wire logic [LIT_W-1:0]  dec_lit;
	wire logic [OFS_W-1:0]  dec_ofs;
	wire logic              at_q1;
	wire logic              at_q3;
	wire logic              at_q4;
	wire logic              idle;
	wire logic              first_cyc;
	wire logic              ev_decode;
	wire logic              ev_push;
	wire logic              ev_read;
	wire logic              ev_commit;
	wire logic              ev_dest;
	wire logic              ev_write;
	wire logic              ev_done;
	wire logic              ptr_upd;
	wire logic [1:0]        add_sel;
	wire logic [PTR_W-1:0]  add_base;
	wire logic [PTR_W-1:0]  add_sum;
	wire logic [ADDR_W-1:0] src_addr;
	wire logic [PC_W-1:0]   call_target;
	wire logic [PC_W-1:0]   pc_target;

	// reset release through two stages, assertion stays asynchronous
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_reg   <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end else begin
			rst_meta_reg   <= 1'b1;
			rst_sync_n_reg <= rst_meta_reg;
		end
	end

	assign rst_n = rst_sync_n_reg;

	// configuration bit may come from another domain at power-up
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ext_meta_reg <= 1'b0;
			ext_en_reg   <= 1'b0;
		end else begin
			ext_meta_reg <= EXT_SET_ENABLE;
			ext_en_reg   <= ext_meta_reg;
		end
	end

	xpe_decode u_decode (
		.instr        (INSTR),
		.ext_en       (ext_en_reg),
		.is_ptr_add   (dec_add),
		.is_add_ret   (dec_ret),
		.is_call_work (dec_call),
		.is_move      (dec_move),
		.ptr_sel      (dec_sel),
		.lit          (dec_lit),
		.ofs          (dec_ofs)
	);

	// four phases per instruction cycle, free running after reset
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			q_reg <= PH_Q1;
		end else begin
			q_reg <= q_reg + 2'h1;
		end
	end

	assign at_q1     = (q_reg == PH_Q1);
	assign at_q3     = (q_reg == PH_Q3);
	assign at_q4     = (q_reg == PH_Q4);
	assign idle      = (state_reg == ST_IDLE);
	assign first_cyc = idle & claim_reg;
	assign dec_any   = dec_add | dec_ret | dec_call | dec_move;

	assign ev_decode = at_q1 & idle & INSTR_VALID & dec_any;
	assign ev_push   = at_q3 & first_cyc & op_call_reg;
	assign ev_read   = at_q3 & first_cyc & op_move_reg;
	assign ev_commit = at_q4 & first_cyc;
	assign ev_dest   = at_q1 & (state_reg == ST_MOVE_WR);
	assign ev_write  = at_q3 & (state_reg == ST_MOVE_WR);
	assign ev_done   = at_q4 & ~idle;

	// frame pointer is forced for the return form
	assign add_sel  = op_ret_reg ? SEL_FRAME : sel_reg;
	assign add_base = ptr_reg[add_sel];
	assign ptr_upd  = ev_commit & (op_add_reg | op_ret_reg);

	xpe_ptr_add #(
		.PTR_W (PTR_W),
		.LIT_W (LIT_W)
	) u_ptr_add (
		.base (add_base),
		.lit  (lit_reg),
		.sum  (add_sum)
	);

	xpe_ptr_add #(
		.PTR_W (ADDR_W),
		.LIT_W (OFS_W)
	) u_src_add (
		.base (ptr_reg[SEL_FRAME]),
		.lit  (ofs_reg),
		.sum  (src_addr)
	);

	// call target only splices registers; nothing is saved to shadows
	assign call_target = {PC_UPPER_LATCH[PC_W-2*DATA_W-1:0], PC_HIGH_LATCH,
		WORK_REG};
	assign pc_target = op_ret_reg ? STACK_TOP : call_target;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (ev_commit && op_ret_reg) begin
					state_next = ST_RET_NOP;
				end else if (ev_commit && op_call_reg) begin
					state_next = ST_CALL_NOP;
				end else if (ev_commit && op_move_reg) begin
					state_next = ST_MOVE_WR;
				end
			end
			ST_RET_NOP,
			ST_CALL_NOP,
			ST_MOVE_WR: begin
				if (ev_done) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// opcode fields held for the whole instruction
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			op_add_reg  <= 1'b0;
			op_ret_reg  <= 1'b0;
			op_call_reg <= 1'b0;
			op_move_reg <= 1'b0;
			sel_reg     <= 2'h0;
			lit_reg     <= '0;
			ofs_reg     <= '0;
		end else if (ev_decode) begin
			op_add_reg  <= dec_add;
			op_ret_reg  <= dec_ret;
			op_call_reg <= dec_call;
			op_move_reg <= dec_move;
			sel_reg     <= dec_sel;
			lit_reg     <= dec_lit;
			ofs_reg     <= dec_ofs;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			claim_reg <= 1'b0;
		end else if (ev_decode) begin
			claim_reg <= 1'b1;
		end else if ((ev_commit && op_add_reg) || ev_done) begin
			claim_reg <= 1'b0;
		end
	end

	// pointer file; the block's own update beats a core write
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_PTR; i++) begin
				ptr_reg[i] <= PTR_RST;
			end
		end else if (ptr_upd) begin
			ptr_reg[add_sel] <= add_sum;
		end else if (PTR_WR_EN && (PTR_WR_SEL != SEL_RETURN)) begin
			ptr_reg[PTR_WR_SEL] <= PTR_WR_DATA;
		end
	end

	// move source: flag indirect hits at address time
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			src_ind_reg   <= 1'b0;
			move_data_reg <= MOVE_NULL_DATA;
			dest_reg      <= '0;
		end else begin
			if (ev_read) begin
				src_ind_reg <= xpe_is_indirect(src_addr);
			end
			if (ev_commit && op_move_reg) begin
				move_data_reg <= src_ind_reg ? MOVE_NULL_DATA : DATA_RD_DATA;
			end
			if (ev_dest) begin
				dest_reg <= INSTR[ADDR_W-1:0];
			end
		end
	end

	// program-flow strobes, one clock wide
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			PC_LOAD          <= 1'b0;
			PC_LOAD_VALUE    <= '0;
			STACK_PUSH       <= 1'b0;
			STACK_PUSH_VALUE <= '0;
			STACK_POP        <= 1'b0;
		end else begin
			PC_LOAD   <= ev_commit & (op_ret_reg | op_call_reg);
			STACK_POP <= ev_commit & op_ret_reg;
			STACK_PUSH <= ev_push;
			if (ev_commit) begin
				PC_LOAD_VALUE <= pc_target;
			end
			if (ev_push) begin
				STACK_PUSH_VALUE <= PC_NOW + PC_RET_STEP;
			end
		end
	end

	// data-space strobes; the second cycle has no read at all
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			DATA_RD_EN   <= 1'b0;
			DATA_RD_ADDR <= '0;
			DATA_WR_EN   <= 1'b0;
			DATA_WR_ADDR <= '0;
			DATA_WR_DATA <= '0;
		end else begin
			DATA_RD_EN <= ev_read & ~xpe_is_indirect(src_addr);
			DATA_WR_EN <= ev_write;
			if (ev_read) begin
				DATA_RD_ADDR <= src_addr;
			end
			if (ev_write) begin
				DATA_WR_ADDR <= dest_reg;
				DATA_WR_DATA <= move_data_reg;
			end
		end
	end

	// status lines, kept registered like every other output
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			Q_PHASE   <= PH_Q1;
			EXT_CLAIM <= 1'b0;
			NOP_CYCLE <= 1'b0;
			PTR0      <= PTR_RST;
			PTR1      <= PTR_RST;
			PTR2      <= PTR_RST;
		end else begin
			Q_PHASE   <= q_reg;
			EXT_CLAIM <= claim_reg;
			NOP_CYCLE <= (state_reg == ST_RET_NOP)
				| (state_reg == ST_CALL_NOP);
			PTR0      <= ptr_reg[0];
			PTR1      <= ptr_reg[1];
			PTR2      <= ptr_reg[2];
		end
	end

	// destination never checked against PC low or stack-top bytes; software keeps clear

endmodule

/* File: bench/xpe_exec_assertions.sv */
`timescale 1ns/100ps
module xpe_exec_assertions (
	input wire logic                        CLK,
	input wire logic                        RESET_N,
	input wire logic                        EXT_SET_ENABLE,
	input wire logic [xpe_pkg::INSTR_W-1:0] INSTR,
	input wire logic [xpe_pkg::PC_W-1:0]    PC_NOW,
	input wire logic [xpe_pkg::DATA_W-1:0]  WORK_REG,
	input wire logic [xpe_pkg::DATA_W-1:0]  PC_HIGH_LATCH,
	input wire logic [xpe_pkg::DATA_W-1:0]  PC_UPPER_LATCH,
	input wire logic [xpe_pkg::PC_W-1:0]    STACK_TOP,
	input wire logic [xpe_pkg::DATA_W-1:0]  DATA_RD_DATA,
	input wire logic                        EXT_CLAIM,
	input wire logic                        NOP_CYCLE,
	input wire logic                        PC_LOAD,
	input wire logic [xpe_pkg::PC_W-1:0]    PC_LOAD_VALUE,
	input wire logic                        STACK_PUSH,
	input wire logic [xpe_pkg::PC_W-1:0]    STACK_PUSH_VALUE,
	input wire logic                        STACK_POP,
	input wire logic                        DATA_RD_EN,
	input wire logic [xpe_pkg::ADDR_W-1:0]  DATA_RD_ADDR,
	input wire logic                        DATA_WR_EN,
	input wire logic [xpe_pkg::ADDR_W-1:0]  DATA_WR_ADDR,
	input wire logic [xpe_pkg::DATA_W-1:0]  DATA_WR_DATA,
	input wire logic [xpe_pkg::PTR_W-1:0]   PTR2
);
	import xpe_pkg::*;
	logic [3:0] dis_cnt_reg;
	// fifteen cycles cover the enable synchroniser plus an op already in flight
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			dis_cnt_reg <= 4'h0;
		end else begin
			dis_cnt_reg <= EXT_SET_ENABLE ? 4'h0 : dis_cnt_reg + 4'(dis_cnt_reg != 4'hF);
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	property p_push_value;
		STACK_PUSH |-> STACK_PUSH_VALUE == PC_NOW + 21'h2;
	endproperty
	a_push_value: assert property (p_push_value) else $error("push value wrong");
	property p_call_load;
		STACK_PUSH |=> PC_LOAD && PC_LOAD_VALUE == {PC_UPPER_LATCH[4:0], PC_HIGH_LATCH, WORK_REG};
	endproperty
	a_call_load: assert property (p_call_load) else $error("call target wrong");
	property p_call_nop;
		STACK_PUSH |-> ##[2:4] NOP_CYCLE;
	endproperty
	a_call_nop: assert property (p_call_nop) else $error("call second cycle missing");
	property p_pop_load;
		STACK_POP |-> PC_LOAD && PC_LOAD_VALUE == STACK_TOP && !STACK_PUSH;
	endproperty
	a_pop_load: assert property (p_pop_load) else $error("return target wrong");
	property p_ret_nop;
		STACK_POP |-> ##[1:3] NOP_CYCLE;
	endproperty
	a_ret_nop: assert property (p_ret_nop) else $error("return second cycle missing");
	property p_rd_addr;
		DATA_RD_EN |-> DATA_RD_ADDR == 12'(PTR2 + INSTR[6:0]);
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("source address wrong");
	property p_wr_addr;
		DATA_WR_EN |-> DATA_WR_ADDR == INSTR[11:0];
	endproperty
	a_wr_addr: assert property (p_wr_addr) else $error("destination wrong");
	property p_rd_wr;
		DATA_RD_EN |-> ##4 DATA_WR_EN && DATA_WR_DATA == $past(DATA_RD_DATA, 4);
	endproperty
	a_rd_wr: assert property (p_rd_wr) else $error("move data wrong");
	property p_disabled;
		dis_cnt_reg == 4'hF |-> !EXT_CLAIM;
	endproperty
	a_disabled: assert property (p_disabled) else $error("claim while disabled");
	c_call: cover property (STACK_PUSH);
	c_ret: cover property (STACK_POP);
	c_move: cover property (DATA_WR_EN);
endmodule
bind xpe_exec xpe_exec_assertions u_xpe_exec_assertions (.CLK(CLK), .RESET_N(RESET_N),
	.EXT_SET_ENABLE(EXT_SET_ENABLE), .INSTR(INSTR), .PC_NOW(PC_NOW), .WORK_REG(WORK_REG),
	.PC_HIGH_LATCH(PC_HIGH_LATCH), .PC_UPPER_LATCH(PC_UPPER_LATCH), .STACK_TOP(STACK_TOP),
	.DATA_RD_DATA(DATA_RD_DATA), .EXT_CLAIM(EXT_CLAIM), .NOP_CYCLE(NOP_CYCLE),
	.PC_LOAD(PC_LOAD), .PC_LOAD_VALUE(PC_LOAD_VALUE), .STACK_PUSH(STACK_PUSH),
	.STACK_PUSH_VALUE(STACK_PUSH_VALUE), .STACK_POP(STACK_POP), .DATA_RD_EN(DATA_RD_EN),
	.DATA_RD_ADDR(DATA_RD_ADDR), .DATA_WR_EN(DATA_WR_EN), .DATA_WR_ADDR(DATA_WR_ADDR),
	.DATA_WR_DATA(DATA_WR_DATA), .PTR2(PTR2));

/* File: bench/xpe_exec_tb.sv */
`timescale 1ns/100ps
module xpe_exec_tb;
	import xpe_pkg::*;
	logic        CLK = 1'b0, RESET_N = 1'b0, EXT_SET_ENABLE = 1'b1, INSTR_VALID = 1'b0;
	logic [15:0] INSTR = 16'h0000;
	logic [20:0] PC_NOW = 21'h0, STACK_TOP = 21'h0, PC_LOAD_VALUE, STACK_PUSH_VALUE;
	logic [7:0]  WORK_REG = 8'h0, PC_HIGH_LATCH = 8'h0, PC_UPPER_LATCH = 8'h0;
	logic [7:0]  DATA_RD_DATA = 8'h0, DATA_WR_DATA;
	logic        PTR_WR_EN = 1'b0;
	logic [1:0]  PTR_WR_SEL = 2'h0, Q_PHASE;
	logic [11:0] PTR_WR_DATA = 12'h0, DATA_RD_ADDR, DATA_WR_ADDR, PTR0, PTR1, PTR2;
	logic        EXT_CLAIM, NOP_CYCLE, PC_LOAD, STACK_PUSH, STACK_POP, DATA_RD_EN, DATA_WR_EN;
	logic [20:0] pc_v, stk_v, push_val, load_val;
	logic [7:0]  wk_v, hil_v, upl_v, rd_v, wr_data;
	logic [11:0] ptr [3] = '{12'h0, 12'h0, 12'h0};
	logic [11:0] rd_addr, wr_addr, a, dest;
	logic [15:0] bad [8] = '{16'h0015, 16'hE900, 16'hEB80, 16'h0000,
	                         16'hE805, 16'hE8C5, 16'h0014, 16'hEB05};
	logic [6:0]  ofs;
	logic [5:0]  k;
	logic        ind;
	int          n_fail = 0, n_compared = 0, cyc = 0, seed;
	int          n_push, n_load, n_pop, n_rd, n_wr, n_nop, n_claim;

	xpe_exec u_xpe_exec (.CLK(CLK), .RESET_N(RESET_N), .EXT_SET_ENABLE(EXT_SET_ENABLE),
		.INSTR(INSTR), .INSTR_VALID(INSTR_VALID), .PC_NOW(PC_NOW), .WORK_REG(WORK_REG),
		.PC_HIGH_LATCH(PC_HIGH_LATCH), .PC_UPPER_LATCH(PC_UPPER_LATCH), .STACK_TOP(STACK_TOP),
		.DATA_RD_DATA(DATA_RD_DATA), .PTR_WR_EN(PTR_WR_EN), .PTR_WR_SEL(PTR_WR_SEL),
		.PTR_WR_DATA(PTR_WR_DATA), .Q_PHASE(Q_PHASE), .EXT_CLAIM(EXT_CLAIM),
		.NOP_CYCLE(NOP_CYCLE), .PC_LOAD(PC_LOAD), .PC_LOAD_VALUE(PC_LOAD_VALUE),
		.STACK_PUSH(STACK_PUSH), .STACK_PUSH_VALUE(STACK_PUSH_VALUE), .STACK_POP(STACK_POP),
		.DATA_RD_EN(DATA_RD_EN), .DATA_RD_ADDR(DATA_RD_ADDR), .DATA_WR_EN(DATA_WR_EN),
		.DATA_WR_ADDR(DATA_WR_ADDR), .DATA_WR_DATA(DATA_WR_DATA), .PTR0(PTR0), .PTR1(PTR1),
		.PTR2(PTR2));

	always #25 CLK = ~CLK;

	// outputs settle well before the falling edge
	always @(negedge CLK) begin
		if (STACK_PUSH === 1'b1) begin
			n_push++;
			push_val = STACK_PUSH_VALUE;
		end
		if (PC_LOAD === 1'b1) begin
			n_load++;
			load_val = PC_LOAD_VALUE;
		end
		if (STACK_POP === 1'b1) begin
			n_pop++;
		end
		if (DATA_RD_EN === 1'b1) begin
			n_rd++;
			rd_addr = DATA_RD_ADDR;
		end
		if (DATA_WR_EN === 1'b1) begin
			n_wr++;
			wr_addr = DATA_WR_ADDR;
			wr_data = DATA_WR_DATA;
		end
		if (NOP_CYCLE === 1'b1) begin
			n_nop++;
		end
		if (EXT_CLAIM === 1'b1) begin
			n_claim++;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic expect_all(input int ep, el, eo, er, ew, en, ec);
		chk(n_push, ep);
		chk(n_load, el);
		chk(n_pop, eo);
		chk(n_rd, er);
		chk(n_wr, ew);
		chk(n_nop, en);
		chk(32'(n_claim != 0), ec);
		chk(PTR0, ptr[0]);
		chk(PTR1, ptr[1]);
		chk(PTR2, ptr[2]);
	endtask

	task automatic core_wr(input logic [1:0] s, input logic [11:0] d);
		@(posedge CLK);
		PTR_WR_EN <= 1'b1;
		PTR_WR_SEL <= s;
		PTR_WR_DATA <= d;
		@(posedge CLK);
		PTR_WR_EN <= 1'b0;
		// select 3 on the core port is ignored
		if (s != 2'h3) begin
			ptr[s] = d;
		end
	endtask

	// word 1 at the start of Q1, word 2 at the start of Q1 one instruction cycle later
	task automatic issue(input logic [15:0] w1, input logic [15:0] w2);
		pc_v = 21'($random(seed));
		stk_v = 21'($random(seed));
		{wk_v, hil_v, upl_v, rd_v} = $random(seed);
		@(negedge CLK);
		while (Q_PHASE !== PH_Q3) @(negedge CLK);
		@(posedge CLK);
		INSTR <= w1;
		INSTR_VALID <= 1'b1;
		PC_NOW <= pc_v;
		STACK_TOP <= stk_v;
		WORK_REG <= wk_v;
		PC_HIGH_LATCH <= hil_v;
		PC_UPPER_LATCH <= upl_v;
		DATA_RD_DATA <= rd_v;
		n_push = 0;
		n_load = 0;
		n_pop = 0;
		n_rd = 0;
		n_wr = 0;
		n_nop = 0;
		n_claim = 0;
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		repeat (3) @(posedge CLK);
		INSTR <= w2;
		INSTR_VALID <= 1'b1;
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		repeat (8) @(posedge CLK);
	endtask

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		seed = 32375;
		repeat (2) @(posedge CLK);
		RESET_N <= 1'b1;
		repeat (6) @(posedge CLK);
		// carry into the high part first, then every select near the 12-bit wrap
		core_wr(2'h2, 12'h3FF);
		for (int i = -1; i < 6; i++) begin
			if (i >= 0) core_wr(2'(i % 3), 12'($random(seed)) | 12'hFC0);
			k = (i < 0) ? 6'h23 : 6'($random(seed));
			ptr[(i < 0) ? 2 : i % 3] += 12'(k);
			issue({8'hE8, 2'((i < 0) ? 2 : i % 3), k}, 16'h0000);
			expect_all(0, 0, 0, 0, 0, 0, 1);
		end
		// a valid add in the second cycle must be ignored
		for (int i = 0; i < 2; i++) begin
			k = 6'($random(seed));
			ptr[2] += 12'(k);
			issue({8'hE8, 2'h3, k}, 16'hE83F);
			expect_all(0, 1, 1, 0, 0, 4, 1);
			chk(load_val, stk_v);
			issue(16'h0014, 16'h0000);
			expect_all(1, 1, 0, 0, 0, 4, 1);
			chk(push_val, 21'(pc_v + 21'h2));
			chk(load_val, {upl_v[4:0], hil_v, wk_v});
		end
		for (int i = 0; i < 4; i++) begin
			ofs = 7'($random(seed));
			dest = 12'($random(seed)) & 12'hEFF;
			if (i == 1) core_wr(2'h2, IND_BASE1 + IND_SPAN - 12'h1 - 12'(ofs));
			if (i == 2) core_wr(2'h2, IND_BASE2 + IND_SPAN - 12'(ofs));
			a = ptr[2] + 12'(ofs);
			ind = (a - IND_BASE0 < IND_SPAN) || (a - IND_BASE1 < IND_SPAN) || (a - IND_BASE2 < IND_SPAN);
			issue({8'hEB, 1'b0, ofs}, {4'hF, dest});
			expect_all(0, 0, 0, ind ? 0 : 1, 1, 0, 1);
			chk(wr_addr, dest);
			chk(wr_data, ind ? 8'h00 : rd_v);
			if (!ind) chk(rd_addr, a);
		end
		// select 3 on the core port must leave every pointer alone
		core_wr(2'h3, 12'hABC);
		// non-extended words, then all four opcodes with the set switched off
		for (int i = 0; i < 8; i++) begin
			if (i == 4) EXT_SET_ENABLE <= 1'b0;
			issue(bad[i], 16'h0000);
			expect_all(0, 0, 0, 0, 0, 0, 0);
		end
		conclude();
	end
endmodule
